// *** verilog/bstat_core.sv ***
// Purpose: four-port tester status, edge latching, counters and interrupt gating
// Assumes: framer bit strobes on CLK; software on a byte register port
// Notes: read data is registered, one cycle after the read strobe
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "bstat_defines.svh"
`default_nettype none

module bstat_core #(
	parameter int PORTS = 4,
	parameter logic [5:0] LOS_ERRORS = `BSTAT_LOS_ERRORS
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic [PORTS-1:0] RX_BIT_EN,
	input wire logic [PORTS-1:0] RX_BIT,
	input wire logic [PORTS-1:0] RX_MATCH,
	input wire logic [PORTS-1:0] PATTERN_SELECT_FIELD_DALY,
	output logic [PORTS-1:0] OCTET55_PATTERN_SELECT,
	output logic [PORTS-1:0] TX_PATTERN_BYTE_ALIGN,
	output logic [PORTS-1:0] LIVE_PATTERN_LOCKED,
	output logic IRQ
);

	// address split: port in bits 5:4, port-1 address otherwise
	wire logic [1:0] port_sel = ADDR[5:4];
	wire logic [15:0] base_addr = {ADDR[15:6], 2'b00, ADDR[3:0]};
	wire logic port_ok = ({30'h0, port_sel} < PORTS);

	wire logic hit_ts = port_ok && (base_addr == `BSTAT_OFS_TESTER_STATUS);
	wire logic hit_tsm = port_ok && (base_addr == `BSTAT_OFS_TESTER_STATUS_IRQ_MASK);
	wire logic hit_xc = port_ok && (base_addr == `BSTAT_OFS_EXTENDED_PATTERN_CONTROL);
	wire logic hit_el = port_ok && (base_addr == `BSTAT_OFS_CONDITION_EDGE_LATCHES);
	wire logic hit_elm = port_ok && (base_addr == `BSTAT_OFS_CONDITION_EDGE_IRQ_MASK);
	wire logic hit_ov = port_ok && (base_addr == `BSTAT_OFS_ERROR_OVERFLOW_LATCHES);
	wire logic hit_ovm = port_ok && (base_addr == `BSTAT_OFS_ERROR_OVERFLOW_IRQ_MASK);

	// per-port register images for the read mux
	logic [7:0] rd_ts [PORTS];
	logic [7:0] rd_tsm [PORTS];
	logic [7:0] rd_xc [PORTS];
	logic [7:0] rd_live [PORTS];
	logic [7:0] rd_el [PORTS];
	logic [7:0] rd_elm [PORTS];
	logic [7:0] rd_ov [PORTS];
	logic [7:0] rd_ovm [PORTS];
	logic [31:0] rd_bits [PORTS];
	logic [23:0] rd_errs [PORTS];
	logic [PORTS-1:0] port_irq;

	genvar p;
	generate
		for (p = 0; p < PORTS; p++) begin : g_port
			wire logic sel = port_ok && (port_sel == p);
			wire logic bit_en = RX_BIT_EN[p];

			bstat_pkg::bstat_sync_t state;
			bstat_pkg::bstat_sync_t next_state;
			logic [5:0] match_run;
			logic [5:0] ones_run;
			logic [5:0] zeros_run;
			logic [5:0] win_cnt;
			logic [5:0] win_err;
			logic [31:0] bit_count;
			logic [23:0] err_count;
			bstat_pkg::bstat_cond_t cond_q;
			logic [3:0] entry_flag;
			logic [3:0] exit_flag;
			logic [2:0] ov_flag;
			logic [7:0] ts_mask;
			logic [7:0] el_mask;
			logic [2:0] ov_mask;
			logic [1:0] xctl;
			logic align_pulse;

			// live conditions
			wire logic all_ones_condition = (ones_run == `BSTAT_RUN_LEN);
			wire logic all_zeros_condition = (zeros_run == `BSTAT_RUN_LEN);
			wire logic pattern_hunt_condition = (state == bstat_pkg::BSTAT_HUNT);
			wire logic pattern_locked_condition = (state == bstat_pkg::BSTAT_LOCK);
			wire bstat_pkg::bstat_cond_t cond = {all_ones_condition, all_zeros_condition,
				pattern_hunt_condition, pattern_locked_condition};
			wire bstat_pkg::bstat_cond_t cond_rise = cond & ~cond_q;
			wire bstat_pkg::bstat_cond_t cond_fall = ~cond & cond_q;

			// error only counts while locked
			wire logic bit_error_event = pattern_locked_condition && bit_en
				&& !RX_MATCH[p];
			wire logic bit_inc = pattern_locked_condition && bit_en;
			wire logic bit_wrap = bit_inc && (bit_count == 32'hFFFFFFFF);
			wire logic err_wrap = bit_error_event && (err_count == 24'hFFFFFF);
			wire logic win_end = bit_inc && (win_cnt == `BSTAT_LOS_WINDOW);
			wire logic [5:0] win_err_now = win_err + {5'h00, bit_error_event};
			wire logic too_many = bit_inc && (win_err_now >= LOS_ERRORS);

			// write-one clears; entry flags and bit error from either status register, exit flags and wraps from their latch register only
			wire logic [3:0] clr_entry = (WR && sel && hit_ts) ? WDATA[3:0] :
				(WR && sel && hit_el) ? WDATA[3:0] : 4'h0;
			wire logic [3:0] clr_exit = (WR && sel && hit_el) ? WDATA[7:4] : 4'h0;
			wire logic clr_berr = (WR && sel && hit_ts && WDATA[`BSTAT_TS_BIT_ERROR])
				|| (WR && sel && hit_ov && WDATA[`BSTAT_OV_BIT_ERROR]);
			wire logic [2:0] clr_ov = {clr_berr,
				(WR && sel && hit_ov) ? WDATA[1:0] : 2'h0};
			wire logic [2:0] set_ov = {bit_error_event, bit_wrap, err_wrap};

			// lock tracker: idle until the first bit, then hunt for 32 matches
			always_comb begin
				next_state = state;
				case (state)
					bstat_pkg::BSTAT_IDLE: begin
						if (bit_en)
							next_state = bstat_pkg::BSTAT_HUNT;
					end
					bstat_pkg::BSTAT_HUNT: begin
						if (bit_en && RX_MATCH[p] && (match_run == `BSTAT_RUN_LEN - 6'h01))
							next_state = bstat_pkg::BSTAT_LOCK;
					end
					bstat_pkg::BSTAT_LOCK: begin
						if (too_many)
							next_state = bstat_pkg::BSTAT_HUNT;
					end
					default: next_state = bstat_pkg::BSTAT_IDLE;
				endcase
			end

			always_ff @(posedge CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					state <= bstat_pkg::BSTAT_IDLE;
				end else begin
					state <= next_state;
				end
			end

			// match run only matters while hunting
			always_ff @(posedge CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					match_run <= 6'h00;
				end else if (!pattern_hunt_condition) begin
					match_run <= 6'h00;
				end else if (bit_en) begin
					match_run <= RX_MATCH[p] ? match_run + 6'h01 : 6'h00;
				end
			end

			// saturating runs of ones and zeros
			always_ff @(posedge CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					ones_run <= 6'h00;
					zeros_run <= 6'h00;
				end else if (bit_en) begin
					if (RX_BIT[p]) begin
						ones_run <= all_ones_condition ? ones_run : ones_run + 6'h01;
						zeros_run <= 6'h00;
					end else begin
						zeros_run <= all_zeros_condition ? zeros_run : zeros_run + 6'h01;
						ones_run <= 6'h00;
					end
				end
			end

			// loss of lock: too many errors in one 64-bit window
			always_ff @(posedge CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					win_cnt <= 6'h00;
					win_err <= 6'h00;
				end else if (!pattern_locked_condition || too_many) begin
					win_cnt <= 6'h00;
					win_err <= 6'h00;
				end else if (bit_inc) begin
					win_cnt <= win_cnt + 6'h01;
					win_err <= win_end ? 6'h00 : win_err_now;
				end
			end

			// counters wrap freely; the wrap is what gets flagged
			always_ff @(posedge CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					bit_count <= 32'h00000000;
					err_count <= 24'h000000;
				end else begin
					if (bit_inc)
						bit_count <= bit_count + 32'h00000001;
					if (bit_error_event)
						err_count <= err_count + 24'h000001;
				end
			end

			// sticky flags: set beats a same-cycle clear
			always_ff @(posedge CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					cond_q <= 4'h0;
					entry_flag <= 4'h0;
					exit_flag <= 4'h0;
					ov_flag <= 3'h0;
				end else begin
					cond_q <= cond;
					entry_flag <= (entry_flag & ~clr_entry) | cond_rise;
					exit_flag <= (exit_flag & ~clr_exit) | cond_fall;
					ov_flag <= (ov_flag & ~clr_ov) | set_ov;
				end
			end

			// masks and extended control
			always_ff @(posedge CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					ts_mask <= `BSTAT_RESET_BYTE;
					el_mask <= `BSTAT_RESET_BYTE;
					ov_mask <= 3'h0;
					xctl <= 2'h0;
					align_pulse <= 1'b0;
				end else begin
					if (WR && sel && hit_tsm)
						ts_mask <= {1'b0, WDATA[6], 2'b00, WDATA[3:0]};
					if (WR && sel && hit_elm)
						el_mask <= WDATA;
					if (WR && sel && hit_ovm)
						ov_mask <= WDATA[2:0];
					if (WR && sel && hit_xc)
						xctl <= WDATA[1:0];
					// only a written 0-to-1 edge realigns
					align_pulse <= WR && sel && hit_xc && WDATA[`BSTAT_XC_ALIGN]
						&& !xctl[`BSTAT_XC_ALIGN];
				end
			end

			// basic mask covers both edges of each condition
			wire logic irq_basic = (|(entry_flag & ts_mask[3:0]))
				|| (|(exit_flag & ts_mask[3:0]))
				|| (ov_flag[2] && ts_mask[`BSTAT_TS_BIT_ERROR]);
			wire logic irq_ext = (|({exit_flag, entry_flag} & el_mask))
				|| (|(ov_flag & ov_mask));
			assign port_irq[p] = irq_basic || irq_ext;

			assign OCTET55_PATTERN_SELECT[p] = xctl[`BSTAT_XC_OCTET55]
				&& PATTERN_SELECT_FIELD_DALY[p];
			assign TX_PATTERN_BYTE_ALIGN[p] = align_pulse;
			assign LIVE_PATTERN_LOCKED[p] = pattern_locked_condition;

			assign rd_ts[p] = {1'b0, ov_flag[2],
				all_zeros_condition || all_ones_condition,
				pattern_locked_condition,
				entry_flag};
			assign rd_tsm[p] = ts_mask;
			assign rd_xc[p] = {6'h00, xctl};
			assign rd_live[p] = {4'h0, cond};
			assign rd_el[p] = {exit_flag, entry_flag};
			assign rd_elm[p] = el_mask;
			assign rd_ov[p] = {5'h00, ov_flag};
			assign rd_ovm[p] = {5'h00, ov_mask};
			assign rd_bits[p] = bit_count;
			assign rd_errs[p] = err_count;
		end
	endgenerate

	// read select; unmapped addresses read zero
	wire logic [7:0] rd_sel =
		!port_ok ? 8'h00 :
		(base_addr == `BSTAT_OFS_BIT_COUNT0) ? rd_bits[port_sel][7:0] :
		(base_addr == `BSTAT_OFS_BIT_COUNT1) ? rd_bits[port_sel][15:8] :
		(base_addr == `BSTAT_OFS_BIT_COUNT2) ? rd_bits[port_sel][23:16] :
		(base_addr == `BSTAT_OFS_BIT_COUNT3) ? rd_bits[port_sel][31:24] :
		(base_addr == `BSTAT_OFS_ERR_COUNT0) ? rd_errs[port_sel][7:0] :
		(base_addr == `BSTAT_OFS_ERR_COUNT1) ? rd_errs[port_sel][15:8] :
		(base_addr == `BSTAT_OFS_ERROR_COUNT_BYTE2) ? rd_errs[port_sel][23:16] :
		hit_ts ? rd_ts[port_sel] :
		hit_tsm ? rd_tsm[port_sel] :
		hit_xc ? rd_xc[port_sel] :
		(base_addr == `BSTAT_OFS_LIVE_CONDITION_STATUS) ? rd_live[port_sel] :
		hit_el ? rd_el[port_sel] :
		hit_elm ? rd_elm[port_sel] :
		hit_ov ? rd_ov[port_sel] :
		hit_ovm ? rd_ovm[port_sel] : 8'h00;

	// data stands only in the cycle after the strobe
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RDATA <= 8'h00;
			IRQ <= 1'b0;
		end else begin
			RDATA <= RD ? rd_sel : 8'h00;
			IRQ <= |port_irq;
		end
	end

endmodule

`default_nettype wire

// *** verilog/bstat_defines.svh ***
// Purpose: constants for the per-port tester status and interrupt block
// Assumes: byte-wide register port, 16-bit addresses, 25 MHz clock
// Notes: offsets are the port-1 addresses; port n adds PORT_STRIDE x (n-1)
`ifndef BSTAT_DEFINES_SVH
`define BSTAT_DEFINES_SVH

`define BSTAT_PORT_STRIDE 16'h0010
`define BSTAT_ADDR_W 16
`define BSTAT_DATA_W 8

// basic bank
`define BSTAT_OFS_BIT_COUNT0 16'h1107
`define BSTAT_OFS_BIT_COUNT1 16'h1108
`define BSTAT_OFS_BIT_COUNT2 16'h1109
`define BSTAT_OFS_BIT_COUNT3 16'h110A
`define BSTAT_OFS_ERR_COUNT0 16'h110B
`define BSTAT_OFS_ERR_COUNT1 16'h110C
`define BSTAT_OFS_ERROR_COUNT_BYTE2 16'h110D
`define BSTAT_OFS_TESTER_STATUS 16'h110E
`define BSTAT_OFS_TESTER_STATUS_IRQ_MASK 16'h110F
// extended bank
`define BSTAT_OFS_EXTENDED_PATTERN_CONTROL 16'h1400
`define BSTAT_OFS_LIVE_CONDITION_STATUS 16'h1401
`define BSTAT_OFS_CONDITION_EDGE_LATCHES 16'h1402
`define BSTAT_OFS_CONDITION_EDGE_IRQ_MASK 16'h1403
`define BSTAT_OFS_ERROR_OVERFLOW_LATCHES 16'h1404
`define BSTAT_OFS_ERROR_OVERFLOW_IRQ_MASK 16'h1405

// field positions
`define BSTAT_TS_BIT_ERROR 6
`define BSTAT_TS_ZEROS_OR_ONES 5
`define BSTAT_TS_LOCKED 4
`define BSTAT_XC_OCTET55 1
`define BSTAT_XC_ALIGN 0
`define BSTAT_OV_BIT_ERROR 2
`define BSTAT_OV_BIT_WRAP 1
`define BSTAT_OV_ERR_WRAP 0

// reset values
`define BSTAT_RESET_BYTE 8'h00

// timing and counts
`define BSTAT_RUN_LEN 6'h20
`define BSTAT_LOS_WINDOW 6'h3F
`define BSTAT_LOS_ERRORS 6'h06

`endif

// *** verilog/bstat_pkg.sv ***
// Purpose: types for the per-port tester status block
// Assumes: constants live in bstat_defines.svh
// Notes: none
package bstat_pkg;
	// one-hot lock tracker states
	typedef enum logic [2:0] {
		BSTAT_IDLE = 3'b001,
		BSTAT_HUNT = 3'b010,
		BSTAT_LOCK = 3'b100
	} bstat_sync_t;
	// condition vector order: {all ones, all zeros, hunt, locked}
	typedef logic [3:0] bstat_cond_t;
endpackage

// *** verif/bstat_core_props.sv ***
// Purpose: port-level checks for the tester status block
// Assumes: one clock, async active-high reset
// Notes: lane 0 only except the unmapped-read and IRQ checks, to keep helper logic small
`timescale 1ns/1ps
`default_nettype none
module bstat_core_props #(
	parameter int PORTS = 4
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic [PORTS-1:0] RX_BIT_EN,
	input wire logic [PORTS-1:0] RX_MATCH,
	input wire logic [PORTS-1:0] PATTERN_SELECT_FIELD_DALY,
	input wire logic [PORTS-1:0] OCTET55_PATTERN_SELECT,
	input wire logic [PORTS-1:0] TX_PATTERN_BYTE_ALIGN,
	input wire logic [PORTS-1:0] LIVE_PATTERN_LOCKED,
	input wire logic IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	logic [1:0] ctl;
	logic rise, armed;
	logic [5:0] run;
	wire ctl_wr = WR && ADDR == 16'h1400;
	// any nonzero mask write; conservative, never cleared
	wire mask_wr = WR && WDATA != 8'h00 && (ADDR[3:0] == 4'hF || ADDR[3:0] == 4'h3
		|| ADDR[3:0] == 4'h5);
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctl <= 2'h0;
			rise <= 1'b0;
			armed <= 1'b0;
			run <= 6'h00;
		end else begin
			if (ctl_wr)
				ctl <= WDATA[1:0];
			rise <= ctl_wr && WDATA[0] && !ctl[0];
			armed <= armed || mask_wr;
			if (RX_BIT_EN[0])
				run <= !RX_MATCH[0] ? 6'h00 : (run == 6'h3F ? run : run + 6'h01);
		end
	end
	sequence rd_at(logic [15:0] a);
		RD && ADDR == a;
	endsequence
	unmapped_read_a: assert property (RD && ADDR[15:8] == 8'h14 && ADDR[7:4] > 4'h3
		|=> RDATA == 8'h00) else $error("unmapped read not zero");
	live_pad_a: assert property (rd_at(16'h1401) |=> RDATA[7:4] == 4'h0)
		else $error("live status upper bits set");
	status_lock_a: assert property (rd_at(16'h110E)
		|=> RDATA[4] == $past(LIVE_PATTERN_LOCKED[0])) else $error("status lock bit wrong");
	align_pulse_a: assert property (TX_PATTERN_BYTE_ALIGN[0] == rise)
		else $error("align pulse wrong");
	align_short_a: assert property (TX_PATTERN_BYTE_ALIGN[0] |=> !TX_PATTERN_BYTE_ALIGN[0])
		else $error("align pulse too long");
	octet_sel_a: assert property (OCTET55_PATTERN_SELECT[0] ==
		(ctl[1] && PATTERN_SELECT_FIELD_DALY[0])) else $error("octet select wrong");
	irq_quiet_a: assert property (!armed |-> !IRQ) else $error("irq with masks clear");
	lock_rise_a: assert property ($rose(LIVE_PATTERN_LOCKED[0])
		|-> $past(RX_BIT_EN[0]) && run >= 6'h20) else $error("lock too early");
endmodule
`default_nettype wire

// *** verif/bstat_framer.sv ***
// Purpose: behavioural framer receive side giving bit strobes
// Assumes: a request cycle yields one strobe on the next cycle
// Notes: idle data lines invert so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module bstat_framer (
	input wire logic clk,
	input wire logic req,
	input wire logic [3:0] sel,
	input wire logic v,
	input wire logic m,
	output logic [3:0] en,
	output logic [3:0] bitv,
	output logic [3:0] mat
);
	initial begin
		en = 4'h0;
		bitv = 4'h0;
		mat = 4'h0;
	end
	always @(posedge clk) begin
		if (req) begin
			en <= sel;
			bitv <= {4{v}};
			mat <= {4{m}};
		end else begin
			en <= 4'h0;
			bitv <= ~bitv;
			mat <= ~mat;
		end
	end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the tester status block
// Assumes: framer model feeds the bit strobes
// Notes: counter wraps are out of reach in a short run and stay unchecked
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic CLK, SYS_RST, WR, RD, IRQ;
	logic [15:0] ADDR;
	logic [7:0] WDATA, RDATA, d;
	logic [3:0] RX_BIT_EN, RX_BIT, RX_MATCH, PATTERN_SELECT_FIELD_DALY;
	logic [3:0] OCTET55_PATTERN_SELECT, TX_PATTERN_BYTE_ALIGN, LIVE_PATTERN_LOCKED, sel;
	logic req, fv, fm, rd_d;
	logic [7:0] exq[$];
	logic [15:0] rst_tab [10] = '{16'h110D, 16'h110E, 16'h110F, 16'h1400, 16'h1401,
		16'h1402, 16'h1403, 16'h1404, 16'h1405, 16'h1440};
	logic [15:0] mk_a [3] = '{16'h110F, 16'h1403, 16'h1405};
	logic [7:0] mk_m [3] = '{8'h4F, 8'hFF, 8'h07};
	int seed = 32'h5EE5;
	int miscompares = 0;
	int checked = 0;
	bstat_core u_bstat_core (.CLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .RX_BIT_EN,
		.RX_BIT, .RX_MATCH, .PATTERN_SELECT_FIELD_DALY, .OCTET55_PATTERN_SELECT,
		.TX_PATTERN_BYTE_ALIGN, .LIVE_PATTERN_LOCKED, .IRQ);
	bstat_framer u_bstat_framer (.clk(CLK), .req, .sel, .v(fv), .m(fm), .en(RX_BIT_EN),
		.bitv(RX_BIT), .mat(RX_MATCH));
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	task check(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t saw %h want %h", $time, s, e);
		end
	endtask
	task end_of_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] dv);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= dv;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		exq.push_back(e);
		@(posedge CLK);
		RD <= 1'b0;
	endtask
	// random gaps exercise the slow framer case
	task send(input int p, input logic v, input logic alt, input logic m, input int n);
		repeat (n) begin
			@(posedge CLK);
			req <= 1'b1;
			sel <= 4'h1 << p;
			fv <= v;
			fm <= m;
			v = v ^ alt;
			if ($random(seed) % 4 == 0) begin
				@(posedge CLK);
				req <= 1'b0;
			end
		end
		@(posedge CLK);
		req <= 1'b0;
		repeat (4) @(posedge CLK);
	endtask
	task irq_is(input logic [7:0] e);
		repeat (3) @(posedge CLK);
		@(negedge CLK);
		check({7'h00, IRQ}, e);
	endtask
	always @(posedge CLK) rd_d <= RD;
	always @(negedge CLK) begin
		if (rd_d === 1'b1)
			check(RDATA, exq.pop_front());
	end
	initial begin
		repeat (20000) @(posedge CLK);
		miscompares++;
		end_of_test();
	end
	initial begin
		SYS_RST = 1'b1;
		ADDR = 16'h0000;
		WDATA = 8'h00;
		WR = 1'b0;
		RD = 1'b0;
		{req, fv, fm} = 3'h0;
		sel = 4'h0;
		PATTERN_SELECT_FIELD_DALY = 4'h0;
		repeat (8) @(posedge CLK);
		SYS_RST <= 1'b0;
		foreach (rst_tab[i])
			rd(rst_tab[i], 8'h00);
		wr(16'h1401, 8'hFF);
		rd(16'h1401, 8'h00);
		$display("reset test done");
		for (int p = 0; p < 4; p++) begin
			send(p, 1'b0, 1'b1, 1'b1, 1);
			send(p, 1'b0, 1'b1, 1'b0, 3);
			send(p, 1'b0, 1'b1, 1'b1, 33);
			rd(16'h1401 + 16'(p * 16), 8'h01);
			rd(16'h1402 + 16'(p * 16), 8'h23);
			rd(16'h110E + 16'(p * 16), 8'h13);
			rd(16'h1404 + 16'(p * 16), 8'h00);
			@(negedge CLK);
			check({4'h0, LIVE_PATTERN_LOCKED}, 8'((2 << p) - 1));
		end
		send(0, 1'b0, 1'b1, 1'b0, 1);
		rd(16'h1404, 8'h04);
		rd(16'h110E, 8'h53);
		rd(16'h110B, 8'h01);
		rd(16'h110D, 8'h00);
		wr(16'h1402, 8'hFF);
		wr(16'h110E, 8'h40);
		rd(16'h110E, 8'h10);
		rd(16'h1404, 8'h00);
		$display("lock test done");
		for (int k = 1; k >= 0; k--) begin
			wr(16'h1402, 8'hFF);
			send(0, k[0], 1'b0, 1'b1, 32);
			rd(16'h1401, k ? 8'h09 : 8'h05);
			rd(16'h110E, k ? 8'h38 : 8'h34);
			send(0, !k[0], 1'b0, 1'b1, 1);
			rd(16'h1401, 8'h01);
			rd(16'h1402, k ? 8'h88 : 8'h44);
		end
		$display("ones zeros test done");
		foreach (mk_a[i]) begin
			d = 8'($random(seed));
			wr(mk_a[i], d);
			rd(mk_a[i], d & mk_m[i]);
			wr(mk_a[i], 8'h00);
		end
		irq_is(8'h00);
		wr(16'h1403, 8'h40);
		irq_is(8'h01);
		wr(16'h1403, 8'h80);
		irq_is(8'h00);
		wr(16'h1403, 8'h00);
		wr(16'h110F, 8'h04);
		irq_is(8'h01);
		wr(16'h1402, 8'h04);
		irq_is(8'h01);
		wr(16'h1402, 8'h40);
		irq_is(8'h00);
		wr(16'h110F, 8'h00);
		$display("irq test done");
		wr(16'h1400, 8'h02);
		@(negedge CLK);
		check({4'h0, OCTET55_PATTERN_SELECT}, 8'h00);
		@(posedge CLK);
		PATTERN_SELECT_FIELD_DALY <= 4'hF;
		@(negedge CLK);
		check({4'h0, OCTET55_PATTERN_SELECT}, 8'h01);
		wr(16'h1400, 8'h03);
		@(negedge CLK);
		check({4'h0, TX_PATTERN_BYTE_ALIGN}, 8'h01);
		wr(16'h1400, 8'h03);
		@(negedge CLK);
		check({4'h0, TX_PATTERN_BYTE_ALIGN}, 8'h00);
		rd(16'h1400, 8'h03);
		$display("control test done");
		// six errors inside one window drop port 0 back to hunting
		wr(16'h1402, 8'hFF);
		send(0, 1'b0, 1'b1, 1'b0, 6);
		rd(16'h1401, 8'h02);
		rd(16'h1402, 8'h12);
		rd(16'h1404, 8'h04);
		rd(16'h1107, 8'h4A);
		rd(16'h1108, 8'h00);
		rd(16'h110B, 8'h07);
		@(negedge CLK);
		check({4'h0, LIVE_PATTERN_LOCKED}, 8'h0E);
		$display("loss test done");
		repeat (4) @(posedge CLK);
		end_of_test();
	end
endmodule
bind bstat_core bstat_core_props #(.PORTS(PORTS)) u_bstat_core_props (.CLK, .SYS_RST, .ADDR,
	.WDATA, .WR, .RD, .RDATA, .RX_BIT_EN, .RX_MATCH, .PATTERN_SELECT_FIELD_DALY,
	.OCTET55_PATTERN_SELECT, .TX_PATTERN_BYTE_ALIGN, .LIVE_PATTERN_LOCKED, .IRQ);
`default_nettype wire
